// ---- rtl/bmx_consts.vh ----
// Constants for the byte move / OR / pointer load execution block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef BMX_CONSTS_VH
`define BMX_CONSTS_VH

// ----------------------------------------
// Register byte offsets (low address byte)
// ----------------------------------------
`define BMX_OFF_CTRL 8'h00
`define BMX_OFF_INSTR 8'h04
`define BMX_OFF_ACC 8'h08
`define BMX_OFF_BANK 8'h0C
`define BMX_OFF_FLAGS 8'h10
`define BMX_OFF_STATUS 8'h14
`define BMX_OFF_PTR0 8'h18
`define BMX_OFF_PTR1 8'h1C
`define BMX_OFF_PTR2 8'h20
`define BMX_OFF_MEM_ADDR 8'h24
`define BMX_OFF_MEM_DATA 8'h28

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BMX_CTRL_EXT_BIT 0
`define BMX_FLG_Z_BIT 2
`define BMX_FLG_N_BIT 4
`define BMX_ST_PEND_LO 0
`define BMX_ST_BAD_DEST_BIT 2
`define BMX_ST_BAD_OP_BIT 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BMX_RST_BYTE 8'h00
`define BMX_RST_BANK 4'h0
`define BMX_RST_PTR 12'h000
`define BMX_RST_ADDR 12'h000

// ----------------------------------------
// Opcode prefixes and address map
// ----------------------------------------
`define BMX_OP_IOR 6'h04
`define BMX_OP_MOVE 6'h14
`define BMX_OP_LDPTR1 8'hEE
`define BMX_OP_LDPTR2 8'hF0
`define BMX_OP_LONG1 4'hC
`define BMX_OP_LONG2 4'hF
`define BMX_ACCESS_LIMIT 8'h5F
`define BMX_ACCESS_UPPER 4'hF
`define BMX_ADDR_ACC 12'hFF0
`define BMX_ADDR_PC_LOW 12'hFF1
`define BMX_ADDR_RET_LOW 12'hFF2
`define BMX_ADDR_RET_HIGH 12'hFF3
`define BMX_ADDR_RET_UPPER 12'hFF4
`define BMX_INDEX_PTR 2'd2

`endif

// ---- rtl/bmx_addr_resolve.v ----
// File operand to data space address resolver.
// Assumes a combinational caller supplying bank and index pointer values.
`default_nettype none
`include "bmx_consts.vh"

module bmx_addr_resolve (
  input wire [7:0] file_sel,
  input wire bank_bit,
  input wire ext_en,
  input wire [3:0] bank_sel,
  input wire [11:0] index_base,
  output wire [11:0] data_addr
);

  // ----------------------------------------
  // Mode selection
  // ----------------------------------------
  wire low_part;
  wire indexed;
  wire [11:0] access_addr;
  wire [11:0] indexed_addr;

  // Fast access region splits at the limit address
  assign low_part = (file_sel <= `BMX_ACCESS_LIMIT);
  assign indexed = ext_en & ~bank_bit & low_part;
  assign access_addr = low_part ? {4'h0, file_sel} : {`BMX_ACCESS_UPPER, file_sel};
  assign indexed_addr = index_base + {4'h0, file_sel};

  // Bank selector supplies the upper nibble when the bit is set
  assign data_addr = bank_bit ? {bank_sel, file_sel} :
    (indexed ? indexed_addr : access_addr);

endmodule // bmx_addr_resolve

`default_nettype wire

// ---- rtl/bmx_exec_top.v ----
// Execution block for OR-with-file, move-file, pointer load and long move.
// Assumes an AHB-Lite master, one slave, hready fed back from hreadyout.
//
// Chosen here: the address map and register access over AHB-Lite.
`default_nettype none
`include "bmx_consts.vh"

module bmx_exec_top #(
  parameter DATA_AW = 12,
  parameter [11:0] ACC_ADDR = `BMX_ADDR_ACC,
  parameter [11:0] PC_LOW_ADDR = `BMX_ADDR_PC_LOW,
  parameter [11:0] RET_LOW_ADDR = `BMX_ADDR_RET_LOW,
  parameter [11:0] RET_HIGH_ADDR = `BMX_ADDR_RET_HIGH,
  parameter [11:0] RET_UPPER_ADDR = `BMX_ADDR_RET_UPPER
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp
);

  // ----------------------------------------
  // Pending second-word states
  // ----------------------------------------
  localparam [1:0] PEND_NONE = 2'b00;
  localparam [1:0] PEND_PTR = 2'b01;
  localparam [1:0] PEND_LONG = 2'b10;
  localparam DEPTH = 1 << DATA_AW;

  reg [7:0] mem_reg [0:DEPTH-1];
  reg [7:0] acc_reg, acc_next;
  reg [7:0] flags_reg, flags_next;
  reg [3:0] bank_reg, bank_next;
  reg ext_reg, ext_next;
  reg [1:0] pend_reg, pend_next;
  reg [1:0] psel_reg, psel_next;
  reg [7:0] latch_reg, latch_next;
  reg bad_dest_reg, bad_dest_next;
  reg bad_op_reg, bad_op_next;
  reg [11:0] ptr_reg [0:2];
  reg [11:0] maddr_reg, maddr_next;
  reg [15:0] last_reg, last_next;
  reg [7:0] addr_reg;
  reg wr_pend_reg;
  reg rd_pend_reg;
  reg dw_en;
  reg [11:0] dw_addr;
  reg [7:0] dw_data;
  reg ph_en, pl_en;
  reg [3:0] ph_val;
  reg [7:0] res;
  reg [31:0] rd_value;
  wire take;
  wire inst_go;
  wire [15:0] iw;
  wire [11:0] faddr;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Data space read with the accumulator overlaid
  function [7:0] rd_byte;
    input [11:0] a;
    begin
      if (a == ACC_ADDR) begin
        rd_byte = acc_reg;
      end else begin
        rd_byte = mem_reg[a[DATA_AW-1:0]];
      end
    end
  endfunction

  // Destinations the long move may not touch
  function bad_target;
    input [11:0] a;
    begin
      bad_target = (a == PC_LOW_ADDR) || (a == RET_LOW_ADDR) ||
        (a == RET_HIGH_ADDR) || (a == RET_UPPER_ADDR);
    end
  endfunction

  // ----------------------------------------
  // Bus phases
  // ----------------------------------------
  assign take = hsel & hready & htrans[1];
  assign iw = hwdata[15:0];
  assign inst_go = wr_pend_reg && (addr_reg == `BMX_OFF_INSTR);

  // Capture address phase; reads get one wait state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend_reg <= take & hwrite;
      rd_pend_reg <= take & ~hwrite;
      hreadyout <= ~(take & ~hwrite);
      hresp <= 1'b0;
      if (take) begin
        addr_reg <= haddr[7:0];
      end
      if (rd_pend_reg) begin
        hrdata <= rd_value;
      end
    end
  end

  // Operand address of the byte-oriented word
  bmx_addr_resolve u_resolve (
    .file_sel(iw[7:0]),
    .bank_bit(iw[8]),
    .ext_en(ext_reg),
    .bank_sel(bank_reg),
    .index_base(ptr_reg[`BMX_INDEX_PTR]),
    .data_addr(faddr)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    rd_value = 32'h00000000;
    case (addr_reg)
      `BMX_OFF_CTRL: rd_value[`BMX_CTRL_EXT_BIT] = ext_reg;
      `BMX_OFF_INSTR: rd_value[15:0] = last_reg;
      `BMX_OFF_ACC: rd_value[7:0] = acc_reg;
      `BMX_OFF_BANK: rd_value[3:0] = bank_reg;
      `BMX_OFF_FLAGS: rd_value[7:0] = flags_reg;
      `BMX_OFF_STATUS: begin
        rd_value[`BMX_ST_PEND_LO+1:`BMX_ST_PEND_LO] = pend_reg;
        rd_value[`BMX_ST_BAD_DEST_BIT] = bad_dest_reg;
        rd_value[`BMX_ST_BAD_OP_BIT] = bad_op_reg;
      end
      `BMX_OFF_PTR0: rd_value[11:0] = ptr_reg[0];
      `BMX_OFF_PTR1: rd_value[11:0] = ptr_reg[1];
      `BMX_OFF_PTR2: rd_value[11:0] = ptr_reg[2];
      `BMX_OFF_MEM_ADDR: rd_value[11:0] = maddr_reg;
      `BMX_OFF_MEM_DATA: rd_value[7:0] = rd_byte(maddr_reg);
      default: rd_value = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Execution and register writes
  // ----------------------------------------
  always @* begin
    acc_next = acc_reg;
    flags_next = flags_reg;
    bank_next = bank_reg;
    ext_next = ext_reg;
    pend_next = pend_reg;
    psel_next = psel_reg;
    latch_next = latch_reg;
    bad_dest_next = bad_dest_reg;
    bad_op_next = bad_op_reg;
    maddr_next = maddr_reg;
    last_next = last_reg;
    dw_en = 1'b0;
    dw_addr = 12'h000;
    dw_data = 8'h00;
    ph_en = 1'b0;
    pl_en = 1'b0;
    ph_val = 4'h0;
    res = 8'h00;
    // Software clears sticky errors by writing ones
    if (wr_pend_reg && addr_reg == `BMX_OFF_STATUS) begin
      if (hwdata[`BMX_ST_BAD_DEST_BIT]) bad_dest_next = 1'b0;
      if (hwdata[`BMX_ST_BAD_OP_BIT]) bad_op_next = 1'b0;
    end
    if (wr_pend_reg) begin
      case (addr_reg)
        `BMX_OFF_CTRL: ext_next = hwdata[`BMX_CTRL_EXT_BIT];
        `BMX_OFF_ACC: acc_next = hwdata[7:0];
        `BMX_OFF_BANK: bank_next = hwdata[3:0];
        `BMX_OFF_FLAGS: flags_next = hwdata[7:0];
        `BMX_OFF_MEM_ADDR: maddr_next = hwdata[11:0];
        `BMX_OFF_MEM_DATA: begin
          dw_en = 1'b1;
          dw_addr = maddr_reg;
          dw_data = hwdata[7:0];
        end
        default: ;
      endcase
    end
    // Each instruction word executes in its own data phase
    if (inst_go) begin
      last_next = iw;
      case (pend_reg)
        PEND_NONE: begin
          if (iw[15:10] == `BMX_OP_IOR || iw[15:10] == `BMX_OP_MOVE) begin
            if (iw[15:10] == `BMX_OP_IOR) begin
              res = acc_reg | rd_byte(faddr);
            end else begin
              res = rd_byte(faddr);
            end
            flags_next[`BMX_FLG_N_BIT] = res[7];
            flags_next[`BMX_FLG_Z_BIT] = (res == 8'h00);
            if (iw[9]) begin
              dw_en = 1'b1;
              dw_addr = faddr;
              dw_data = res;
            end else begin
              acc_next = res;
            end
          end else if (iw[15:8] == `BMX_OP_LDPTR1 && iw[7:6] == 2'b00 &&
              iw[5:4] != 2'b11) begin
            pend_next = PEND_PTR;
            psel_next = iw[5:4];
            ph_en = 1'b1;
            ph_val = iw[3:0];
          end else if (iw[15:12] == `BMX_OP_LONG1) begin
            latch_next = rd_byte(iw[11:0]);
            pend_next = PEND_LONG;
          end else begin
            bad_op_next = 1'b1;
          end
        end
        PEND_PTR: begin
          pend_next = PEND_NONE;
          if (iw[15:8] == `BMX_OP_LDPTR2) begin
            pl_en = 1'b1;
          end else begin
            bad_op_next = 1'b1;
          end
        end
        PEND_LONG: begin
          pend_next = PEND_NONE;
          if (iw[15:12] != `BMX_OP_LONG2) begin
            bad_op_next = 1'b1;
          end else if (bad_target(iw[11:0])) begin
            bad_dest_next = 1'b1;
          end else begin
            dw_en = 1'b1;
            dw_addr = iw[11:0];
            dw_data = latch_reg;
          end
        end
        default: pend_next = PEND_NONE;
      endcase
    end
    // Writes aimed at the accumulator address land in it
    if (dw_en && dw_addr == ACC_ADDR) begin
      acc_next = dw_data;
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_reg <= `BMX_RST_BYTE;
      flags_reg <= `BMX_RST_BYTE;
      bank_reg <= `BMX_RST_BANK;
      ext_reg <= 1'b0;
      pend_reg <= PEND_NONE;
      psel_reg <= 2'b00;
      latch_reg <= `BMX_RST_BYTE;
      bad_dest_reg <= 1'b0;
      bad_op_reg <= 1'b0;
      maddr_reg <= `BMX_RST_ADDR;
      last_reg <= 16'h0000;
      ptr_reg[0] <= `BMX_RST_PTR;
      ptr_reg[1] <= `BMX_RST_PTR;
      ptr_reg[2] <= `BMX_RST_PTR;
    end else begin
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      bank_reg <= bank_next;
      ext_reg <= ext_next;
      pend_reg <= pend_next;
      psel_reg <= psel_next;
      latch_reg <= latch_next;
      bad_dest_reg <= bad_dest_next;
      bad_op_reg <= bad_op_next;
      maddr_reg <= maddr_next;
      last_reg <= last_next;
      // High nibble first, low byte with the second word
      if (ph_en) begin
        ptr_reg[iw[5:4]] <= {ph_val, ptr_reg[iw[5:4]][7:0]};
      end
      if (pl_en) begin
        ptr_reg[psel_reg] <= {ptr_reg[psel_reg][11:8], iw[7:0]};
      end
    end
  end

  // Data space storage, accumulator address excluded
  always @(posedge hclk) begin
    if (dw_en && dw_addr != ACC_ADDR) begin
      mem_reg[dw_addr[DATA_AW-1:0]] <= dw_data;
    end
  end

endmodule // bmx_exec_top

`default_nettype wire

// ---- verif/bmx_exec_sva.sv ----
// Checker for the execution block, seeing only its bus ports.
// Assumes hready is fed from hreadyout and a single slave on the bus.
`default_nettype none
module bmx_exec_sva (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire hresp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Read phase tracking
  // ----
  reg rd_reg;
  reg [7:0] off_reg;
  wire done = rd_reg && hready;
  wire rq = hsel && hready && htrans[1];
  // Remember the offset of the read in its data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_reg <= 1'b0;
      off_reg <= 8'h00;
    end else if (hready) begin
      rd_reg <= hsel && htrans[1] && !hwrite;
      off_reg <= haddr[7:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rd_wait; rq && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_fast; rq && hwrite |=> hreadyout; endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_hold; !(rd_reg && !hready) |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_pend; done && off_reg == 8'h14 |-> hrdata[1:0] != 2'b11; endproperty
  a_pend: assert property (p_pend) else $error("bad pending code");
  property p_ptr; done && off_reg inside {8'h18, 8'h1C, 8'h20} |-> hrdata[31:12] == 0;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer too wide");
  property p_acc; done && off_reg == 8'h08 |-> hrdata[31:8] == 0; endproperty
  a_acc: assert property (p_acc) else $error("accumulator too wide");
  property p_bank; done && off_reg == 8'h0C |-> hrdata[31:4] == 0; endproperty
  a_bank: assert property (p_bank) else $error("bank too wide");
endmodule // bmx_exec_sva

bind bmx_exec_top bmx_exec_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
`default_nettype wire

// ---- verif/bmx_exec_top_tb.sv ----
// Self-checking bench for the execution block over AHB-Lite.
// Assumes hready fed from hreadyout and a 100 MHz hclk.
`default_nettype none
`include "bmx_consts.vh"
module bmx_exec_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, q;
  logic [1:0] htrans;
  wire hreadyout, hresp;
  wire [31:0] hrdata;
  int n_fail = 0, comparisons = 0, cycles = 0;
  integer seed;
  bmx_exec_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
  // ----
  // Clock, limit and bus tasks
  // ----
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Cut a hang short
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      close_out;
    end
  end
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic mw(input logic [11:0] a, input logic [7:0] d);
    wr(8'h24, {20'h0, a});
    wr(8'h28, {24'h0, d});
  endtask
  task automatic mr(input logic [11:0] a, input logic [7:0] e);
    wr(8'h24, {20'h0, a});
    rdc(8'h28, {24'h0, e});
  endtask
  // Expected data address of a file operand
  function automatic logic [11:0] eff(input logic [7:0] f, input logic ab, input logic ext,
      input logic [3:0] bk, input logic [11:0] p2);
    if (ab) return {bk, f};
    if (f > `BMX_ACCESS_LIMIT) return {4'hF, f};
    return ext ? p2 + {4'h0, f} : {4'h0, f};
  endfunction
  // Expected flags after a result
  function automatic logic [7:0] nz(input logic [7:0] o, input logic [7:0] r);
    return (o & 8'hEB) | {3'b000, r[7], 1'b0, r == 8'h00, 2'b00};
  endfunction
  // ----
  // Main sequence
  // ----
  initial begin
    logic [7:0] f, acc, m, fl, r;
    logic [11:0] k, sa, da;
    logic [3:0] bk;
    logic ab, ext, d, isor;
    seed = 32'h5d28;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(8'h14, 32'h0);
    wr(8'h3C, 32'h5A);
    rdc(8'h3C, 32'h0);
    // Pointer loads into each pointer, then a bad selector
    for (int i = 0; i < 3; i++) begin
      k = 12'($random(seed)) & 12'h7FF;
      wr(8'h04, {16'h0, 8'hEE, 2'b00, i[1:0], k[11:8]});
      rdc(8'h14, 32'h1);
      wr(8'h04, {16'h0, 8'hF0, k[7:0]});
      rdc(8'h18 + {i[5:0], 2'b00}, {20'h0, k});
    end
    wr(8'h04, {16'h0, 16'hEE30});
    rdc(8'h14, 32'h8);
    wr(8'h14, 32'h8);
    // Random OR and move over every addressing mode
    for (int i = 0; i < 24; i++) begin
      {isor, d, ab, ext} = 4'($random(seed));
      f = 8'($random(seed));
      bk = 4'($random(seed)) & 4'h7;
      if (i < 2) {ab, f} = {1'b0, i ? 8'h60 : 8'h5F};
      if (!ab && f[7:4] == 4'hF) f[7] = 1'b0;
      acc = 8'($random(seed));
      m = 8'($random(seed));
      fl = 8'($random(seed));
      if (i == 2) {acc, m} = 16'h0000;
      da = eff(f, ab, ext, bk, k);
      wr(8'h00, {31'h0, ext});
      wr(8'h0C, {28'h0, bk});
      wr(8'h08, {24'h0, acc});
      wr(8'h10, {24'h0, fl});
      mw(da, m);
      r = isor ? (acc | m) : m;
      wr(8'h04, {16'h0, isor ? 4'h1 : 4'h5, 2'b00, d, ab, f});
      rdc(8'h08, {24'h0, d ? acc : r});
      mr(da, d ? r : m);
      rdc(8'h10, {24'h0, nz(fl, r)});
    end
    // Long moves; source changed between the words
    for (int i = 0; i < 6; i++) begin
      sa = 12'($random(seed)) & 12'hEFF;
      da = sa ^ 12'h801;
      if (i == 1) sa = `BMX_ADDR_ACC;
      if (i == 2) da = `BMX_ADDR_ACC;
      if (i == 3) {sa, da} = 24'h000EFF;
      m = 8'($random(seed));
      fl = 8'($random(seed));
      mw(sa, m);
      wr(8'h10, {24'h0, fl});
      wr(8'h04, {16'h0, 4'hC, sa});
      rdc(8'h14, 32'h2);
      mw(sa, ~m);
      wr(8'h04, {16'h0, 4'hF, da});
      mr(da, m);
      rdc(8'h10, {24'h0, fl});
    end
    // Broken pairs drop the pending word and flag it
    wr(8'h04, 32'hEE05);
    wr(8'h04, 32'h1234);
    rdc(8'h14, 32'h8);
    wr(8'h14, 32'h8);
    wr(8'h04, 32'hC010);
    wr(8'h04, 32'h1234);
    rdc(8'h14, 32'h8);
    wr(8'h14, 32'h8);
    // Forbidden destinations
    mw(12'h010, 8'hC3);
    for (int i = 1; i < 5; i++) begin
      da = `BMX_ADDR_ACC + 12'(i);
      mw(da, 8'h3C);
      wr(8'h04, {16'h0, 16'hC010});
      wr(8'h04, {16'h0, 4'hF, da});
      mr(da, 8'h3C);
      rdc(8'h14, 32'h4);
      wr(8'h14, 32'h4);
    end
    close_out;
  end
endmodule // bmx_exec_top_tb
`default_nettype wire
